// file: design/deadband_gate.sv
`timescale 1ns/1ps
`include "iris_pid_params.svh"

module deadband_gate (
  // Level select and signal in Q14
  input wire logic [3:0] level,
  input wire logic signed [31:0] din,
  output logic signed [31:0] dout
);

  logic [31:0] mag;
  logic [31:0] thr;

  // Level n suppresses below 2^(n-1) fractional steps; 15 is one LSB
  always_comb begin
    mag = din[31] ? 32'(-din) : 32'(din);
    thr = 32'h0000_0001 << (level - 4'h1);
    if ((level != 4'h0) && (mag < thr)) begin
      dout = '0;
    end else begin
      dout = din;
    end
  end

endmodule // deadband_gate

// file: design/iris_pid_params.svh
`ifndef IRIS_PID_PARAMS_SVH
`define IRIS_PID_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define REG_TARGET_ADDR 6'h00
`define REG_GAIN_ADDR 6'h01
`define REG_TUNE_ADDR 6'h02
`define TARGET_RESET 10'h000
`define GAIN_RESET 7'h00
`define TUNE_RESET 16'h0000
`define TARGET_POS 0
`define GAIN_POS 9
`define POLE_POS 12
`define ZERO_POS 8
`define DIFF_POS 4
`define INTG_POS 0

// ----------------------------------------------------------------
// Serial frame layout (bit numbers in order of arrival)
// ----------------------------------------------------------------
`define HDR_LAST_BIT 5'h07
`define FRAME_LAST_BIT 5'h17
`define RW_POS 6

// ----------------------------------------------------------------
// Timing and fixed point
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define CTRL_PERIOD_NS 32000
`define CTRL_CYCLES ((`CTRL_PERIOD_NS) / (`CLK_PERIOD_NS))
`define FRAC_BITS 14
`define ERR_SMOOTH_SHIFT 3
`define COEF_SHIFT 15
`define DIFF_SCALE 4
`define GAIN_BASE 16
`define GAIN_SHIFT 20
`define I_LIMIT 32'sh1000_0000

`endif

// file: design/iris_pid_pkg.sv
package iris_pid_pkg;

  typedef logic [6:0] gain_code_t;
  typedef logic [3:0] tune_sel_t;
  typedef logic signed [31:0] fix_t;

  // Gray coded along IDLE -> HEAD -> BODY -> DONE
  typedef enum logic [1:0] {
    LINK_IDLE = 2'h0,
    LINK_HEAD = 2'h1,
    LINK_BODY = 2'h3,
    LINK_DONE = 2'h2
  } link_state_t;

endpackage

// file: design/iris_pid_tuning.sv
`timescale 1ns/1ps
`include "iris_pid_params.svh"

// Behaviour
// - A 7-bit gain code sits in register 01h and sets overall gain.
// - Code 0 gives 0; else 0.125*2^(hi3-3)*(16+lo4).
// - Gain means ADC-to-motor gain at 35 Hz, 31.25 kHz update rate.
// - Integrator dead zone at 02h: 0 off, n suppresses below 2^(n-15).
// - Differentiator dead zone at 02h, same coding, on input changes.
// - At level 15 the path ignores anything below one LSB.
// - Zero select at 02h picks 10 Hz to 75 Hz from a table.
// - Pole select at 02h picks 710 Hz to 1960 Hz from a table.
// - Reset clears every tuning field to zero.
// - Error is a 10-bit target at 00h minus the ADC reading.

module iris_pid_tuning (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Serial register port
  input wire logic sclk,
  input wire logic cs,
  input wire logic sin,
  output logic sout,
  output logic sout_oe,
  // Position sensor ADC
  input wire logic [9:0] adc_data,
  input wire logic adc_valid,
  // Motor drive
  output logic signed [15:0] motor_drive,
  output logic motor_strobe
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------------------------------
  logic sclk_f, cs_f, sin_f;
  logic sclk_prev_q, cs_prev_q;
  logic sclk_rise, sclk_fall, cs_rise;

  pin_sync #(.W(3)) u_sync (
    .mclk(mclk),
    .reset(reset),
    .pin_in({sclk, cs, sin}),
    .level({sclk_f, cs_f, sin_f})
  );

  always_ff @(posedge mclk) begin
    if (reset) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_f;
      cs_prev_q <= cs_f;
    end
  end

  assign sclk_rise = sclk_f & ~sclk_prev_q;
  assign sclk_fall = ~sclk_f & sclk_prev_q;
  assign cs_rise = cs_f & ~cs_prev_q;

  // ----------------------------------------------------------------
  // Serial frame: 6 address bits, read flag, spare, 16 data, LSB first
  // ----------------------------------------------------------------
  iris_pid_pkg::link_state_t state_q;
  logic [4:0] bit_cnt_q;
  logic [7:0] hdr_q;
  logic [15:0] wdata_q;
  logic [15:0] rd_q;
  logic body_start_q;
  logic commit;
  logic is_read;
  logic [15:0] rd_mux;

  assign is_read = hdr_q[`RW_POS];
  assign commit = (state_q == iris_pid_pkg::LINK_BODY) && sclk_rise &&
                  (bit_cnt_q == `FRAME_LAST_BIT);

  always_ff @(posedge mclk) begin
    if (reset || !cs_f) begin
      state_q <= iris_pid_pkg::LINK_IDLE;
      bit_cnt_q <= 5'h00;
    end else begin
      unique case (state_q)
        iris_pid_pkg::LINK_IDLE: begin
          if (cs_rise) begin
            state_q <= iris_pid_pkg::LINK_HEAD;
          end
        end
        iris_pid_pkg::LINK_HEAD: begin
          if (sclk_rise) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == `HDR_LAST_BIT) begin
              state_q <= iris_pid_pkg::LINK_BODY;
            end
          end
        end
        iris_pid_pkg::LINK_BODY: begin
          if (sclk_rise) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (commit) begin
              state_q <= iris_pid_pkg::LINK_DONE;
            end
          end
        end
        iris_pid_pkg::LINK_DONE: begin
          state_q <= iris_pid_pkg::LINK_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      hdr_q <= 8'h00;
      wdata_q <= 16'h0000;
      body_start_q <= 1'b0;
    end else begin
      body_start_q <= (state_q == iris_pid_pkg::LINK_HEAD) && sclk_rise &&
                      (bit_cnt_q == `HDR_LAST_BIT);
      if (state_q == iris_pid_pkg::LINK_HEAD && sclk_rise) begin
        hdr_q <= {sin_f, hdr_q[7:1]};
      end
      if (state_q == iris_pid_pkg::LINK_BODY && sclk_rise) begin
        wdata_q <= {sin_f, wdata_q[15:1]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [9:0] target_q;
  iris_pid_pkg::gain_code_t gain_q;
  logic [15:0] tune_q;
  logic [15:0] wr_word;

  assign wr_word = {sin_f, wdata_q[15:1]};

  always_ff @(posedge mclk) begin
    if (reset) begin
      target_q <= `TARGET_RESET;
      gain_q <= `GAIN_RESET;
      tune_q <= `TUNE_RESET;
    end else if (commit && !is_read) begin
      unique case (hdr_q[5:0])
        `REG_TARGET_ADDR: target_q <= wr_word[`TARGET_POS +: 10];
        `REG_GAIN_ADDR: gain_q <= wr_word[`GAIN_POS +: 7];
        `REG_TUNE_ADDR: tune_q <= wr_word;
        default: ;
      endcase
    end
  end

  // Unmapped addresses and unused bits read as zero
  always_comb begin
    rd_mux = 16'h0000;
    unique case (hdr_q[5:0])
      `REG_TARGET_ADDR: rd_mux[`TARGET_POS +: 10] = target_q;
      `REG_GAIN_ADDR: rd_mux[`GAIN_POS +: 7] = gain_q;
      `REG_TUNE_ADDR: rd_mux = tune_q;
      default: rd_mux = 16'h0000;
    endcase
  end

  // Data leaves on falling SCLK so the master samples it on the rise
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_q <= 16'h0000;
      sout <= 1'b0;
      sout_oe <= 1'b0;
    end else begin
      sout_oe <= (state_q == iris_pid_pkg::LINK_BODY) && is_read && cs_f;
      if (body_start_q) begin
        rd_q <= rd_mux;
        sout <= rd_mux[0];
      end else if (state_q == iris_pid_pkg::LINK_BODY && sclk_fall &&
                   bit_cnt_q != (`HDR_LAST_BIT + 5'h01)) begin
        rd_q <= {1'b0, rd_q[15:1]};
        sout <= rd_q[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Controller update tick
  // ----------------------------------------------------------------
  localparam int unsigned TICK_CYCLES = `CTRL_CYCLES;
  logic [10:0] tick_cnt_q;
  logic tick;

  assign tick = (tick_cnt_q == 11'(TICK_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (reset || tick) begin
      tick_cnt_q <= 11'h000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // Controller datapath (Q14 fixed point)
  // ----------------------------------------------------------------
  localparam logic [7:0] ZERO_HZ [16] = '{8'h0A, 8'h0F, 8'h14, 8'h19,
    8'h1E, 8'h23, 8'h23, 8'h28, 8'h28, 8'h2D, 8'h32, 8'h37, 8'h3C,
    8'h41, 8'h46, 8'h4B};
  localparam logic [10:0] POLE_HZ [16] = '{11'h2C6, 11'h316, 11'h366,
    11'h3B6, 11'h410, 11'h460, 11'h4B0, 11'h500, 11'h55A, 11'h5AA,
    11'h5FA, 11'h654, 11'h6A4, 11'h6FE, 11'h74E, 11'h7A8};

  logic [9:0] adc_q;
  iris_pid_pkg::fix_t err, e_f_q, e_prev_q, de, e_i, de_d;
  iris_pid_pkg::fix_t i_acc_q, i_next, d_lp_q, y;
  iris_pid_pkg::tune_sel_t zero_sel;
  iris_pid_pkg::tune_sel_t pole_sel;
  logic signed [47:0] i_prod, d_prod, g_prod, g_out;

  assign zero_sel = tune_q[`ZERO_POS +: 4];
  assign pole_sel = tune_q[`POLE_POS +: 4];

  always_ff @(posedge mclk) begin
    if (reset) begin
      adc_q <= 10'h000;
    end else if (adc_valid) begin
      adc_q <= adc_data;
    end
  end

  assign err = ($signed({22'h0, target_q}) - $signed({22'h0, adc_q}))
               <<< `FRAC_BITS;
  assign de = e_f_q - e_prev_q;

  deadband_gate u_intg_db (
    .level(tune_q[`INTG_POS +: 4]),
    .din(e_f_q),
    .dout(e_i)
  );

  deadband_gate u_diff_db (
    .level(tune_q[`DIFF_POS +: 4]),
    .din(de),
    .dout(de_d)
  );

  // Integral weight follows the zero, derivative smoothing the pole
  always_comb begin
    i_prod = 48'(e_i) * $signed({40'h0, ZERO_HZ[zero_sel]});
    i_next = i_acc_q + 32'(i_prod >>> `COEF_SHIFT);
    if (i_next > `I_LIMIT) begin
      i_next = `I_LIMIT;
    end else if (i_next < -`I_LIMIT) begin
      i_next = -`I_LIMIT;
    end
    d_prod = 48'((de_d <<< `DIFF_SCALE) - d_lp_q) *
             $signed({37'h0, POLE_HZ[pole_sel]});
    y = e_f_q + i_acc_q + d_lp_q;
    g_prod = 48'(y) * $signed({43'h0, 5'(`GAIN_BASE) + {1'b0,
             gain_q[3:0]}});
    g_out = g_prod >>> (`GAIN_SHIFT - gain_q[6:4]);
    if (g_out > 48'sh7FFF) begin
      g_out = 48'sh7FFF;
    end else if (g_out < -48'sh8000) begin
      g_out = -48'sh8000;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      e_f_q <= '0;
      e_prev_q <= '0;
      i_acc_q <= '0;
      d_lp_q <= '0;
    end else if (tick) begin
      // Smoothing leaves fractional bits for the dead zones to act on
      e_f_q <= e_f_q + ((err - e_f_q) >>> `ERR_SMOOTH_SHIFT);
      e_prev_q <= e_f_q;
      i_acc_q <= i_next;
      d_lp_q <= d_lp_q + 32'(d_prod >>> `COEF_SHIFT);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      motor_drive <= 16'h0000;
      motor_strobe <= 1'b0;
    end else begin
      motor_strobe <= tick;
      if (tick) begin
        motor_drive <= (gain_q == 7'h00) ? 16'h0000 : g_out[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_clears: assert property (@(posedge mclk)
    $fell(reset) |-> gain_q == 7'h00 && tune_q == 16'h0000)
    else $error("tuning fields not cleared by reset");
  a_gain_write: assert property (@(posedge mclk) disable iff (reset)
    commit && !is_read && hdr_q[5:0] == 6'h01
    |=> gain_q == $past(wr_word[15:9]))
    else $error("gain code not taken from bits 15:9");
  a_tune_layout: assert property (@(posedge mclk) disable iff (reset)
    commit && !is_read && hdr_q[5:0] == 6'h02
    |=> pole_sel == $past(wr_word[15:12]) &&
        tune_q[3:0] == $past(wr_word[3:0]))
    else $error("tuning field layout wrong");
  a_gain_zero: assert property (@(posedge mclk) disable iff (reset)
    tick && gain_q == 7'h00 |=> motor_drive == 16'h0000)
    else $error("zero gain code drove the motor");
  a_intg_off: assert property (@(posedge mclk) disable iff (reset)
    tune_q[3:0] == 4'h0 |-> e_i == e_f_q)
    else $error("integrator dead zone active while off");
  a_intg_floor: assert property (@(posedge mclk) disable iff (reset)
    tune_q[3:0] == 4'hF && e_f_q < 32'sh4000 && e_f_q > -32'sh4000
    |-> e_i == 0)
    else $error("integrator passed input below one LSB");
  a_diff_floor: assert property (@(posedge mclk) disable iff (reset)
    tune_q[7:4] == 4'hF && de < 32'sh4000 && de > -32'sh4000
    |-> de_d == 0)
    else $error("derivative passed change below one LSB");
  a_tick_spacing: assert property (@(posedge mclk) disable iff (reset)
    motor_strobe |=> !motor_strobe [*8])
    else $error("controller updates too close together");
  a_read_drive: assert property (@(posedge mclk) disable iff (reset)
    body_start_q && is_read && cs_f |=> sout_oe ##0
    sout == $past(rd_mux[0]))
    else $error("read data not driven at start of data phase");

endmodule // iris_pid_tuning

// file: design/pin_sync.sv
`timescale 1ns/1ps
`include "iris_pid_params.svh"

module pin_sync #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Pins and filtered levels
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once the last two stages agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk) begin
      if (reset) begin
        lvl_q[i] <= 1'b0;
      end else if (s2_q[i] == s3_q[i]) begin
        lvl_q[i] <= s3_q[i];
      end
    end
  end

  assign level = lvl_q;

endmodule // pin_sync

// file: tb/iris_pid_tuning_test.sv
`timescale 1ns/1ps
`include "iris_pid_params.svh"

module iris_pid_tuning_test;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic sclk = 1'b0;
  logic cs = 1'b0;
  logic sin = 1'b0;
  logic sout, sout_oe, motor_strobe, adc_valid, long_strobe;
  logic signed [15:0] motor_drive;
  logic signed [15:0] d1, dh;
  logic [9:0] adc_data;
  logic [9:0] adc_level = 10'h000;
  logic [15:0] rd;
  int strobe_gap, n_strobes, diff;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #(`CLK_PERIOD_NS / 2) mclk = ~mclk;

  iris_pid_tuning i_iris_pid_tuning (.mclk(mclk), .reset(reset),
    .sclk(sclk), .cs(cs), .sin(sin), .sout(sout), .sout_oe(sout_oe),
    .adc_data(adc_data), .adc_valid(adc_valid),
    .motor_drive(motor_drive), .motor_strobe(motor_strobe));

  iris_plant_model i_iris_plant_model (.mclk(mclk),
    .adc_level(adc_level), .adc_data(adc_data), .adc_valid(adc_valid),
    .motor_strobe(motor_strobe), .strobe_gap(strobe_gap),
    .n_strobes(n_strobes), .long_strobe(long_strobe));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic summarize;
    if (n_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Half periods of 8 mclk leave margin over the pin filter delay
  task automatic xfer(input logic [5:0] a, input logic rdf,
                      input logic [15:0] wd, input int nbits,
                      output logic [15:0] rdv);
    logic [23:0] frame;
    frame = {wd, 1'b0, rdf, a};
    rdv = 16'h0000;
    cs = 1'b1;
    tick(6);
    for (int i = 0; i < nbits; i++) begin
      sin = frame[i];
      tick(8);
      if (rdf && i >= 8) begin
        rdv[i-8] = sout;
        check({15'h0000, sout_oe}, 16'h0001, "sout_oe in read");
      end
      sclk = 1'b1;
      tick(8);
      sclk = 1'b0;
    end
    tick(2);
    cs = 1'b0;
    sin = 1'b0;
    tick(8);
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] x;
    xfer(a, 1'b0, d, 24, x);
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] x;
    xfer(a, 1'b1, 16'h0000, 24, x);
    check(x, e, "register read");
  endtask

  task automatic do_reset;
    reset = 1'b1;
    tick(10);
    reset = 1'b0;
    tick(6);
  endtask

  // Fresh start per code so the filter history is identical
  task automatic run_gain(input logic [6:0] code, input logic [9:0] tgt,
                          input logic [15:0] tune,
                          output logic signed [15:0] d);
    int n0;
    do_reset();
    wr(`REG_TARGET_ADDR, {6'h00, tgt});
    wr(`REG_TUNE_ADDR, tune);
    wr(`REG_GAIN_ADDR, {code, 9'h000});
    n0 = n_strobes;
    for (int k = 0; k < 20000 && n_strobes < n0 + 4; k++) begin
      tick(1);
    end
    d = motor_drive;
    n_tests++;
    if (n_strobes < n0 + 4) begin
      n_errors++;
      $display("MISMATCH %0t controller updates missing", $time);
    end
    check(16'(strobe_gap), 16'(`CTRL_CYCLES), "tick spacing");
  endtask

  // ----------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      $display("MISMATCH %0t run timed out", $time);
      summarize();
    end
  end

  initial begin
    tick(10);
    reset = 1'b0;
    tick(6);
    rdchk(`REG_TARGET_ADDR, 16'h0000);
    rdchk(`REG_GAIN_ADDR, 16'h0000);
    rdchk(`REG_TUNE_ADDR, 16'h0000);
    for (int n = 0; n < 16; n++) begin
      wr(`REG_TUNE_ADDR, {4{4'(n)}});
      rdchk(`REG_TUNE_ADDR, {4{4'(n)}});
    end
    wr(`REG_TUNE_ADDR, 16'h1234);
    rdchk(`REG_TUNE_ADDR, 16'h1234);
    wr(`REG_GAIN_ADDR, 16'hFFFF);
    rdchk(`REG_GAIN_ADDR, 16'hFE00);
    wr(`REG_TARGET_ADDR, 16'hFFFF);
    rdchk(`REG_TARGET_ADDR, 16'h03FF);
    wr(6'h05, 16'hFFFF);
    rdchk(6'h05, 16'h0000);
    // A frame cut short must leave the register alone
    xfer(`REG_TUNE_ADDR, 1'b0, 16'hA5A5, 14, rd);
    rdchk(`REG_TUNE_ADDR, 16'h1234);
    // Integrator dead zone stays off for the gain runs
    adc_level = 10'h1F4;
    run_gain(7'h00, 10'h258, 16'h0000, d1);
    check(d1, 16'h0000, "zero gain drive");
    run_gain(7'h10, 10'h258, 16'h0000, d1);
    n_tests++;
    if (d1 === 16'sh0000 || $isunknown(d1)) begin
      n_errors++;
      $display("MISMATCH %0t no drive at gain code 10h", $time);
    end
    // Each step of the upper three bits doubles the gain
    for (int h = 2; h <= 4; h++) begin
      run_gain({3'(h), 4'h0}, 10'h258, 16'h0000, dh);
      diff = int'(dh) - (int'(d1) <<< (h - 1));
      n_tests++;
      if ($isunknown(dh) || diff < 0 || diff >= (1 << (h - 1))) begin
        n_errors++;
        $display("MISMATCH %0t gain step %0d drive %0d", $time, h, dh);
      end
    end
    // Error under one LSB: both dead zones at 15 must hold the drive down
    run_gain(7'h70, 10'h1F5, 16'h0000, d1);
    run_gain(7'h70, 10'h1F5, 16'h00FF, dh);
    n_tests++;
    if ($isunknown(dh) || dh >= d1) begin
      n_errors++;
      $display("MISMATCH %0t dead zones passed drive %0d", $time, dh);
    end
    wr(`REG_TUNE_ADDR, 16'h1234);
    do_reset();
    check(motor_drive, 16'h0000, "drive after reset");
    rdchk(`REG_GAIN_ADDR, 16'h0000);
    rdchk(`REG_TUNE_ADDR, 16'h0000);
    check({15'h0000, long_strobe}, 16'h0000, "strobe width");
    summarize();
  end
endmodule // iris_pid_tuning_test

// file: tb/iris_plant_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Position sensor ADC and motor stage
// ----------------------------------------------------------------
module iris_plant_model #(
  parameter int VALID_GAP = 16
) (
  // Clock
  input wire logic mclk,
  // Sensor side
  input wire logic [9:0] adc_level,
  output logic [9:0] adc_data,
  output logic adc_valid,
  // Motor side
  input wire logic motor_strobe,
  output int strobe_gap,
  output int n_strobes,
  output logic long_strobe
);
  int div_q = 0;
  int run_q = 0;
  logic prev_q = 1'b0;

  initial begin
    adc_data = 10'h000;
    adc_valid = 1'b0;
    strobe_gap = 0;
    n_strobes = 0;
    long_strobe = 1'b0;
  end

  // Outside the valid cycle the bus shows junk, never the last sample
  always @(negedge mclk) begin
    div_q <= (div_q == VALID_GAP - 1) ? 0 : div_q + 1;
    adc_valid <= (div_q == 0);
    adc_data <= (div_q == 0) ? adc_level : ~adc_level;
  end

  // Strobe interval and width watch
  always @(posedge mclk) begin
    prev_q <= motor_strobe;
    run_q <= motor_strobe ? 1 : run_q + 1;
    if (motor_strobe === 1'b1) begin
      strobe_gap <= run_q;
      n_strobes <= n_strobes + 1;
      if (prev_q === 1'b1) begin
        long_strobe <= 1'b1;
      end
    end
  end
endmodule // iris_plant_model
